// [verilog/bsfu_pkg.sv]
// constants and types of the bit shift and flag unit
// assumes one core clock and a decoder that presents one operation at a time
package bsfu_pkg;
    localparam int          DATA_W      = 8;
    localparam int          IO_ADDR_W   = 5;
    localparam int          IO_CYCLES   = 2;
    localparam int          ALU_CYCLES  = 1;
    localparam logic [2:0]  FLAG_C      = 3'h0;
    localparam logic [2:0]  FLAG_Z      = 3'h1;
    localparam logic [2:0]  FLAG_N      = 3'h2;
    localparam logic [2:0]  FLAG_V      = 3'h3;
    localparam logic [2:0]  FLAG_S      = 3'h4;
    localparam logic [2:0]  FLAG_H      = 3'h5;
    localparam logic [2:0]  FLAG_T      = 3'h6;
    localparam logic [2:0]  FLAG_I      = 3'h7;
    localparam logic [7:0]  STATUS_RST  = 8'h00;
    localparam logic [7:0]  ONE_HOT     = 8'h01;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_SHL_LOGICAL,
        OP_SHR_LOGICAL,
        OP_ROT_LEFT_CARRY,
        OP_ROT_RIGHT_CARRY,
        OP_SHR_SIGNED,
        OP_NIBBLE_SWAP,
        OP_BIT_TO_TFLAG,
        OP_TFLAG_TO_BIT,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_DEBUG_HALT
    } bsfu_op_t;
endpackage : bsfu_pkg

// [verilog/bsfu_shift_if.sv]
// carrier between the core control and the shift datapath
// assumes the package is compiled first
`timescale 1ns/1ps
`default_nettype none
interface bsfu_shift_if;
    import bsfu_pkg::*;
    bsfu_op_t     op;
    logic [7:0]   operand;
    logic         carry_in;
    logic [7:0]   result;
    logic         flag_c;
    logic         flag_z;
    logic         flag_n;
    logic         flag_v;
    modport core (output op, operand, carry_in,
                  input  result, flag_c, flag_z, flag_n, flag_v);
    modport unit (input  op, operand, carry_in,
                  output result, flag_c, flag_z, flag_n, flag_v);
endinterface : bsfu_shift_if
`default_nettype wire

// [verilog/bsfu_shift_unit.sv]
// combinational shifter and rotator with its z c n v flags
// assumes op selects one of the five shift codes, else passes through
`timescale 1ns/1ps
`default_nettype none
module bsfu_shift_unit (
    bsfu_shift_if.unit sh
);
    import bsfu_pkg::*;

    wire        is_shl   = (sh.op == OP_SHL_LOGICAL);
    wire        is_shr   = (sh.op == OP_SHR_LOGICAL);
    wire        is_rol   = (sh.op == OP_ROT_LEFT_CARRY);
    wire        is_ror   = (sh.op == OP_ROT_RIGHT_CARRY);
    wire        is_asr   = (sh.op == OP_SHR_SIGNED);
    wire        left     = is_shl | is_rol;
    wire        fill_lo  = is_rol & sh.carry_in;
    wire        fill_hi  = (is_ror & sh.carry_in) | (is_asr & sh.operand[7]);
    wire [7:0]  shl_val  = {sh.operand[6:0], fill_lo};
    wire [7:0]  shr_val  = {fill_hi, sh.operand[7:1]};
    wire        any_op   = left | is_shr | is_ror | is_asr;

    assign sh.result = !any_op ? sh.operand : (left ? shl_val : shr_val);
    assign sh.flag_c = left ? sh.operand[7] : sh.operand[0];
    assign sh.flag_z = (sh.result == 8'h00);
    assign sh.flag_n = sh.result[7];
    assign sh.flag_v = sh.flag_n ^ sh.flag_c;
endmodule : bsfu_shift_unit
`default_nettype wire

// [verilog/bsfu_top.sv]
// bit shift, bit test and status flag datapath of the core
// assumes io_rdata_i answers io_addr_o in the same cycle as io_re_o
`timescale 1ns/1ps
`default_nettype none
module bsfu_top (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         op_valid_i,
    output logic                              op_ready_o,
    input  wire bsfu_pkg::bsfu_op_t           op_code_i,
    input  wire logic [7:0]                   reg_data_i,
    input  wire logic [2:0]                   bit_sel_i,
    input  wire logic [2:0]                   flag_sel_i,
    input  wire logic [bsfu_pkg::IO_ADDR_W-1:0] io_addr_i,
    input  wire logic [7:0]                   io_rdata_i,
    output logic [bsfu_pkg::IO_ADDR_W-1:0]    io_addr_o,
    output logic                              io_re_o,
    output logic                              io_we_o,
    output logic [7:0]                        io_wdata_o,
    output logic [7:0]                        result_o,
    output logic                              result_we_o,
    output logic [7:0]                        status_flags_o,
    output logic                              debug_halt_o,
    output logic                              done_o
);
    import bsfu_pkg::*;

    typedef enum logic {ST_IDLE, ST_IO_WRITE} bsfu_state_t;

    bsfu_state_t              state_q;
    bsfu_state_t              state_d;
    logic [7:0]               flags_q;
    logic [7:0]               flags_d;
    logic [7:0]               result_q;
    logic [7:0]               result_d;
    logic                     result_we_q;
    logic [7:0]               io_wdata_q;
    logic [IO_ADDR_W-1:0]     io_addr_q;
    logic                     done_q;
    logic                     halt_q;

    bsfu_shift_if sh ();

    bsfu_shift_unit u_shift (
        .sh (sh)
    );

    // decode
    wire        accept     = op_valid_i & op_ready_o;
    wire        is_io_set  = (op_code_i == OP_IO_BIT_SET);
    wire        is_io_clr  = (op_code_i == OP_IO_BIT_CLEAR);
    wire        is_io      = is_io_set | is_io_clr;
    wire        is_shift   = (op_code_i == OP_SHL_LOGICAL) | (op_code_i == OP_SHR_LOGICAL)
                           | (op_code_i == OP_ROT_LEFT_CARRY) | (op_code_i == OP_ROT_RIGHT_CARRY)
                           | (op_code_i == OP_SHR_SIGNED);
    wire        is_swap    = (op_code_i == OP_NIBBLE_SWAP);
    wire        is_bst     = (op_code_i == OP_BIT_TO_TFLAG);
    wire        is_bld     = (op_code_i == OP_TFLAG_TO_BIT);
    wire        is_fset    = (op_code_i == OP_FLAG_SET);
    wire        is_fclr    = (op_code_i == OP_FLAG_CLEAR);
    wire        is_halt    = (op_code_i == OP_DEBUG_HALT);
    wire [7:0]  bit_mask   = ONE_HOT << bit_sel_i;
    wire [7:0]  flag_mask  = ONE_HOT << flag_sel_i;
    wire [7:0]  tflag_mask = ONE_HOT << FLAG_T;
    wire        sel_bit    = |(reg_data_i & bit_mask);
    wire        tflag      = flags_q[FLAG_T];
    wire        in_write   = (state_q == ST_IO_WRITE);

    // shifter operands
    assign sh.op       = op_code_i;
    assign sh.operand  = reg_data_i;
    assign sh.carry_in = flags_q[FLAG_C];

    // status flag next value; only the named flags move
    wire [7:0]  shift_flags = {flags_q[7:4], sh.flag_v, sh.flag_n,
                               sh.flag_z, sh.flag_c};
    wire [7:0]  bst_flags   = sel_bit ? (flags_q | tflag_mask)
                                      : (flags_q & ~tflag_mask);
    wire [7:0]  fset_flags  = flags_q | flag_mask;
    wire [7:0]  fclr_flags  = flags_q & ~flag_mask;

    assign flags_d = !accept  ? flags_q     :
                     is_shift ? shift_flags :
                     is_bst   ? bst_flags   :
                     is_fset  ? fset_flags  :
                     is_fclr  ? fclr_flags  :
                                flags_q;

    // register result
    wire [7:0]  swap_val = {reg_data_i[3:0], reg_data_i[7:4]};
    wire [7:0]  bld_val  = tflag ? (reg_data_i | bit_mask)
                                 : (reg_data_i & ~bit_mask);
    wire        writes_reg = is_shift | is_swap | is_bld;

    assign result_d = is_swap ? swap_val :
                      is_bld  ? bld_val  :
                                sh.result;

    // io read-modify-write
    wire [7:0]  io_mod = is_io_set ? (io_rdata_i | bit_mask)
                                   : (io_rdata_i & ~bit_mask);

    assign state_d    = (accept & is_io) ? ST_IO_WRITE : ST_IDLE;
    assign op_ready_o = !in_write;
    assign io_re_o    = accept & is_io;
    assign io_addr_o  = in_write ? io_addr_q : io_addr_i;
    assign io_we_o    = in_write;
    assign io_wdata_o = io_wdata_q;
    assign result_o   = result_q;
    assign result_we_o    = result_we_q;
    assign status_flags_o = flags_q;
    assign debug_halt_o   = halt_q;
    assign done_o         = done_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q     <= ST_IDLE;
            flags_q     <= STATUS_RST;
            result_q    <= 8'h00;
            result_we_q <= 1'b0;
            io_wdata_q  <= 8'h00;
            io_addr_q   <= '0;
            done_q      <= 1'b0;
            halt_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            flags_q     <= flags_d;
            result_we_q <= accept & writes_reg;
            done_q      <= (accept & !is_io) | in_write;
            halt_q      <= accept & is_halt;
            if (accept & writes_reg) begin
                result_q <= result_d;
            end
            if (accept & is_io) begin
                io_wdata_q <= io_mod;
                io_addr_q  <= io_addr_i;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire  acc_set  = accept & is_io_set;
    wire  acc_clr  = accept & is_io_clr;

    sequence io_write_step;
        ##1 (io_we_o && !op_ready_o && $stable(status_flags_o));
    endsequence

    sequence io_done_step;
        ##1 (op_ready_o && !io_we_o && done_o && $stable(status_flags_o));
    endsequence

    io_set_seq_a: assert property (acc_set |-> io_write_step ##0 io_done_step)
        else $error("io bit set sequence wrong");

    io_set_data_a: assert property (acc_set |=>
        io_wdata_o == ($past(io_rdata_i) | $past(bit_mask)))
        else $error("io bit set data wrong");

    io_clear_data_a: assert property (acc_clr |-> io_write_step ##0
        (io_wdata_o == ($past(io_rdata_i) & ~$past(bit_mask))))
        else $error("io bit clear data wrong");

    shl_result_a: assert property (accept && op_code_i == OP_SHL_LOGICAL |=>
        result_we_o && result_o == {$past(reg_data_i[6:0]), 1'b0}
        && status_flags_o[FLAG_C] == $past(reg_data_i[7]))
        else $error("left shift wrong");

    shr_result_a: assert property (accept && op_code_i == OP_SHR_LOGICAL |=>
        result_o == {1'b0, $past(reg_data_i[7:1])}
        && status_flags_o[FLAG_Z] == (result_o == 8'h00)
        && !status_flags_o[FLAG_N])
        else $error("right shift wrong");

    rol_result_a: assert property (accept && op_code_i == OP_ROT_LEFT_CARRY |=>
        result_o == {$past(reg_data_i[6:0]), $past(flags_q[FLAG_C])}
        && status_flags_o[FLAG_V] == (result_o[7] ^ $past(reg_data_i[7])))
        else $error("rotate left wrong");

    ror_result_a: assert property (accept && op_code_i == OP_ROT_RIGHT_CARRY |=>
        result_o == {$past(flags_q[FLAG_C]), $past(reg_data_i[7:1])}
        && status_flags_o[FLAG_C] == $past(reg_data_i[0]))
        else $error("rotate right wrong");

    asr_result_a: assert property (accept && op_code_i == OP_SHR_SIGNED |=>
        result_o == {$past(reg_data_i[7]), $past(reg_data_i[7:1])}
        && status_flags_o[7:4] == $past(flags_q[7:4]))
        else $error("signed shift wrong");

    bst_flag_a: assert property (accept && is_bst |=>
        status_flags_o[FLAG_T] == $past(sel_bit)
        && (status_flags_o & ~tflag_mask) == ($past(flags_q) & ~tflag_mask))
        else $error("bit store wrong");

    bld_bit_a: assert property (accept && is_bld |=>
        result_we_o && |(result_o & $past(bit_mask)) == $past(tflag)
        && $stable(status_flags_o))
        else $error("bit load wrong");

    flag_set_a: assert property (accept && is_fset |=>
        status_flags_o == ($past(flags_q) | $past(flag_mask)) && done_o)
        else $error("flag set wrong");

    flag_clear_a: assert property (accept && is_fclr |=>
        status_flags_o == ($past(flags_q) & ~$past(flag_mask)) && done_o)
        else $error("flag clear wrong");

    halt_flags_a: assert property (accept && is_halt |=>
        debug_halt_o && $stable(status_flags_o) && !result_we_o)
        else $error("debug halt changed state");

    swap_result_a: assert property (accept && is_swap |=>
        result_o == {$past(reg_data_i[3:0]), $past(reg_data_i[7:4])}
        && $stable(status_flags_o))
        else $error("nibble swap wrong");

    // completion step shared by the one-cycle operations
    sequence op_done_step;
        ##1 (done_o && !io_we_o && op_ready_o);
    endsequence

    io_clear_seq_a: assert property (acc_clr |-> io_write_step ##0 io_done_step)
        else $error("io bit clear sequence wrong");

    io_addr_hold_a: assert property (io_re_o |=>
        io_we_o && io_addr_o == $past(io_addr_o))
        else $error("io write address not held");

    io_strobe_once_a: assert property (io_we_o |=> !io_we_o && op_ready_o)
        else $error("io write strobe too long");

    io_read_pair_a: assert property (io_we_o |-> $past(io_re_o) && !op_ready_o)
        else $error("io write without its read");

    shift_timing_a: assert property (accept && is_shift |->
        op_done_step ##0 result_we_o)
        else $error("shift not done in one cycle");

    shift_keep_a: assert property (accept && is_shift |=>
        status_flags_o[7:4] == $past(flags_q[7:4]))
        else $error("shift touched upper flags");

    shl_flags_a: assert property (accept && op_code_i == OP_SHL_LOGICAL |=>
        status_flags_o[FLAG_Z] == (result_o == 8'h00)
        && status_flags_o[FLAG_N] == result_o[7]
        && status_flags_o[FLAG_V] == (result_o[7] ^ status_flags_o[FLAG_C]))
        else $error("left shift flags wrong");

    shr_flags_a: assert property (accept && op_code_i == OP_SHR_LOGICAL |=>
        status_flags_o[FLAG_C] == $past(reg_data_i[0])
        && status_flags_o[FLAG_V] == $past(reg_data_i[0]))
        else $error("right shift carry wrong");

    rol_flags_a: assert property (accept && op_code_i == OP_ROT_LEFT_CARRY |=>
        status_flags_o[FLAG_C] == $past(reg_data_i[7])
        && status_flags_o[FLAG_Z] == (result_o == 8'h00)
        && status_flags_o[FLAG_N] == result_o[7])
        else $error("rotate left flags wrong");

    ror_flags_a: assert property (accept && op_code_i == OP_ROT_RIGHT_CARRY |=>
        status_flags_o[FLAG_N] == $past(flags_q[FLAG_C])
        && status_flags_o[FLAG_V] == ($past(flags_q[FLAG_C]) ^ $past(reg_data_i[0]))
        && status_flags_o[FLAG_Z] == (result_o == 8'h00))
        else $error("rotate right flags wrong");

    asr_flags_a: assert property (accept && op_code_i == OP_SHR_SIGNED |=>
        status_flags_o[FLAG_C] == $past(reg_data_i[0])
        && status_flags_o[FLAG_N] == $past(reg_data_i[7])
        && status_flags_o[FLAG_Z] == (result_o == 8'h00))
        else $error("signed shift flags wrong");

    bld_keep_a: assert property (accept && is_bld |=>
        (result_o & ~$past(bit_mask)) == ($past(reg_data_i) & ~$past(bit_mask)))
        else $error("bit load touched other bits");

    swap_timing_a: assert property (accept && (is_swap || is_bld) |->
        op_done_step ##0 result_we_o)
        else $error("register write timing wrong");

    flag_timing_a: assert property (accept && (is_fset || is_fclr || is_bst)
        |-> op_done_step ##0 !result_we_o)
        else $error("flag operation timing wrong");

    result_hold_a: assert property (!result_we_o |-> $stable(result_o))
        else $error("result changed without write strobe");

    halt_only_a: assert property (debug_halt_o |-> done_o && !result_we_o)
        else $error("debug halt did more than halt");

    nop_quiet_a: assert property (accept && op_code_i == OP_NOP |=>
        done_o && !result_we_o && $stable(status_flags_o))
        else $error("no-op changed state");
endmodule : bsfu_top
`default_nettype wire

// [verif/bsfu_io_model.sv]
// io register file model on the far side of the io strobes
// assumes reads answer in the same cycle as the read strobe
`timescale 1ns/1ps
`default_nettype none
module bsfu_io_model (
    input  wire logic                           clk_i,
    input  wire logic                           re_i,
    input  wire logic                           we_i,
    input  wire logic [bsfu_pkg::IO_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                     wdata_i,
    output logic [7:0]                          rdata_o
);
    import bsfu_pkg::*;
    logic [7:0] mem_q [32];
    logic [7:0] junk_q;
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem_q[i] = {i[4:0], 3'h5} ^ 8'ha0;
        end
        junk_q = 8'h3c;
    end
    always @(posedge clk_i) begin
        junk_q <= ~junk_q ^ 8'h24;
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end
    // no read strobe: a pattern that moves each cycle, never the stored value
    assign rdata_o = re_i ? mem_q[addr_i] : junk_q;
endmodule : bsfu_io_model
`default_nettype wire

// [verif/bit_shift_flag_unit_bench.sv]
// self-checking bench of the bit shift and flag unit
// assumes package, design and io model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bit_shift_flag_unit_bench;
    import bsfu_pkg::*;
    logic                 clk_i    = 1'b0;
    logic                 rst_n_i  = 1'b0;
    logic                 op_valid = 1'b0;
    bsfu_op_t             op_code  = OP_NOP;
    logic [7:0]           reg_data = 8'h00;
    logic [2:0]           bit_sel  = 3'h0;
    logic [2:0]           flag_sel = 3'h0;
    logic [IO_ADDR_W-1:0] io_addr  = '0;
    wire  [7:0]           io_rdata;
    wire  [IO_ADDR_W-1:0] io_addr_o;
    wire  [7:0]           io_wdata, result, status;
    wire                  op_ready, io_re, io_we, result_we, dbg, done;
    int                   err_total   = 0;
    int                   check_count = 0;
    int                   cycles      = 0;
    logic [7:0]           exp_f       = 8'h00;
    logic [7:0]           exp_io [32];
    logic [8:0]           r;
    bsfu_op_t             shops [5] = '{OP_SHL_LOGICAL, OP_SHR_LOGICAL, OP_ROT_LEFT_CARRY,
                                        OP_ROT_RIGHT_CARRY, OP_SHR_SIGNED};
    logic [7:0]           vals [4]  = '{8'h80, 8'h01, 8'h00, 8'hc3};

    bsfu_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid),
        .op_ready_o(op_ready), .op_code_i(op_code), .reg_data_i(reg_data),
        .bit_sel_i(bit_sel), .flag_sel_i(flag_sel), .io_addr_i(io_addr),
        .io_rdata_i(io_rdata), .io_addr_o(io_addr_o), .io_re_o(io_re), .io_we_o(io_we),
        .io_wdata_o(io_wdata), .result_o(result), .result_we_o(result_we),
        .status_flags_o(status), .debug_halt_o(dbg), .done_o(done));
    bsfu_io_model io_model (.clk_i(clk_i), .re_i(io_re), .we_i(io_we), .addr_i(io_addr_o),
        .wdata_i(io_wdata), .rdata_o(io_rdata));

    always #5 clk_i = ~clk_i;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end

    // returns {carry, result}
    function automatic logic [8:0] shift_ref(bsfu_op_t op, logic [7:0] d, logic cin);
        case (op)
            OP_SHL_LOGICAL:     return {d, 1'b0};
            OP_SHR_LOGICAL:     return {d[0], 1'b0, d[7:1]};
            OP_ROT_LEFT_CARRY:  return {d, cin};
            OP_ROT_RIGHT_CARRY: return {d[0], cin, d[7:1]};
            default:            return {d[0], d[7], d[7:1]};
        endcase
    endfunction : shift_ref

    // one operation; caller sets exp_f beforehand, flags checked at completion
    task automatic do_op(input bsfu_op_t op, input logic [7:0] d, input logic [2:0] b,
                         input logic [2:0] f, input logic [4:0] a);
        logic       io;
        logic [7:0] w;
        io = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR);
        w = (op == OP_IO_BIT_SET) ? (exp_io[a] | (8'h01 << b)) : (exp_io[a] & ~(8'h01 << b));
        @(negedge clk_i);
        op_valid = 1'b1;
        op_code = op;
        reg_data = d;
        bit_sel = b;
        flag_sel = f;
        io_addr = a;
        #1;
        `CHK({op_ready, io_re}, {1'b1, io})
        if (io) begin
            `CHK(io_addr_o, a)
        end
        @(posedge clk_i);
        @(negedge clk_i);
        op_valid = 1'b0;
        if (io) begin
            `CHK({io_we, op_ready, done, io_wdata, io_addr_o}, {3'b100, w, a})
            exp_io[a] = w;
            @(negedge clk_i);
        end
        `CHK({done, io_we, status}, {2'b10, exp_f})
    endtask : do_op

    initial begin
        for (int i = 0; i < 32; i++) begin
            exp_io[i] = {i[4:0], 3'h5} ^ 8'ha0;
        end
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        `CHK({op_ready, done, result_we, io_we, dbg, status, result}, {5'h10, 16'h0000})
        rst_n_i = 1'b1;
        for (int k = 0; k < 24; k++) begin
            exp_f[k % 8] = (k < 8) || (k >= 16);
            do_op((k < 8 || k >= 16) ? OP_FLAG_SET : OP_FLAG_CLEAR, 8'h00, 3'h0,
                  3'(k % 8), 5'h00);
        end
        for (int k = 0; k < 4; k++) begin
            exp_f[k] = 1'b0;
            do_op(OP_FLAG_CLEAR, 8'h00, 3'h0, 3'(k), 5'h00);
        end
        foreach (shops[i]) begin
            foreach (vals[j]) begin
                r = shift_ref(shops[i], vals[j], exp_f[0]);
                exp_f[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
                do_op(shops[i], vals[j], 3'h0, 3'h0, 5'h00);
                `CHK({result_we, result}, {1'b1, r[7:0]})
            end
        end
        do_op(OP_NIBBLE_SWAP, 8'ha6, 3'h0, 3'h0, 5'h00);
        `CHK({result_we, result}, 9'h16a)
        for (int k = 0; k < 8; k++) begin
            exp_f[6] = 1'(8'h96 >> k);
            do_op(OP_BIT_TO_TFLAG, 8'h96, 3'(k), 3'h0, 5'h00);
        end
        do_op(OP_TFLAG_TO_BIT, 8'h00, 3'h3, 3'h0, 5'h00);
        `CHK({result_we, result}, 9'h108)
        exp_f[6] = 1'b0;
        do_op(OP_FLAG_CLEAR, 8'h00, 3'h0, FLAG_T, 5'h00);
        do_op(OP_TFLAG_TO_BIT, 8'hff, 3'h0, 3'h0, 5'h00);
        `CHK(result, 8'hfe)
        do_op(OP_IO_BIT_SET, 8'h00, 3'h7, 3'h0, 5'h1f);
        do_op(OP_IO_BIT_CLEAR, 8'h00, 3'h0, 3'h0, 5'h1f);
        do_op(OP_IO_BIT_SET, 8'h00, 3'h0, 3'h0, 5'h03);
        do_op(OP_IO_BIT_CLEAR, 8'h00, 3'h6, 3'h0, 5'h03);
        // request held through the io write cycle, then one back to back
        @(negedge clk_i);
        op_valid = 1'b1;
        op_code = OP_IO_BIT_SET;
        bit_sel = 3'h1;
        io_addr = 5'h03;
        @(negedge clk_i);
        op_code = OP_FLAG_SET;
        flag_sel = FLAG_T;
        `CHK({op_ready, io_we, io_wdata}, {2'b01, exp_io[3] | 8'h02})
        exp_io[3] = exp_io[3] | 8'h02;
        @(negedge clk_i);
        `CHK({op_ready, done, status}, {2'b11, exp_f})
        @(negedge clk_i);
        exp_f[FLAG_T] = 1'b1;
        `CHK({done, status}, {1'b1, exp_f})
        op_code = OP_FLAG_CLEAR;
        @(negedge clk_i);
        op_valid = 1'b0;
        exp_f[FLAG_T] = 1'b0;
        `CHK({done, status}, {1'b1, exp_f})
        do_op(OP_DEBUG_HALT, 8'h00, 3'h0, 3'h0, 5'h00);
        `CHK({dbg, result_we}, 2'b10)
        do_op(OP_NOP, 8'h55, 3'h0, 3'h0, 5'h00);
        `CHK({dbg, result_we, result}, 10'h0fe)
        summarize();
    end
endmodule : bit_shift_flag_unit_bench
`default_nettype wire
